// ==== core/dpa_pkg.sv ====
/*
 * Package for the data and program space addressing block: address widths,
 * region limits, vector area, operand sizes and the packed request carriers.
 * Assumes a single core clock domain and a 16-bit datapath.
 */
package dpa_pkg;

	localparam int DPA_EA_W = 16;
	localparam int DPA_EXT_W = 24;
	localparam int DPA_PAGE_W = 8;
	localparam int DPA_WORD_W = 16;
	localparam int DPA_BYTE_W = 8;
	localparam int DPA_PROG_W = 24;
	localparam int DPA_PC_W = 23;
	localparam int DPA_NEAR_W = 13;
	localparam int DPA_DEPTH = 256;
	localparam int DPA_IDX_W = 8;

	// Region limits, byte addresses.
	localparam logic [15:0] DPA_CTRL_LAST = 16'h0fff;
	localparam logic [15:0] DPA_NEAR_LAST = 16'h1fff;
	localparam logic [15:0] DPA_IMPL_LAST = 16'hcfff;
	localparam logic [15:0] DPA_XY_BOUNDARY = 16'h9000;
	localparam logic [15:0] DPA_RAM_BASE = 16'h1000;

	// Pointer steps by operand size.
	localparam logic [15:0] DPA_STEP_BYTE = 16'h0001;
	localparam logic [15:0] DPA_STEP_WORD = 16'h0002;

	// Program space limits.
	localparam logic [23:0] DPA_USER_LAST = 24'h7fffff;
	localparam logic [23:0] DPA_VECTOR_LAST = 24'h000200;
	localparam logic [23:0] DPA_RESET_TARGET = 24'h000002;
	localparam logic [23:0] DPA_PROG_STEP = 24'h000002;
	localparam int DPA_TBL_CFG_BIT = 7;

	localparam logic [7:0] DPA_PAGE_RESET = 8'h01;
	localparam logic [7:0] DPA_ZERO_BYTE = 8'h00;
	localparam logic [15:0] DPA_ZERO_WORD = 16'h0000;

	// Program fetch sources.
	typedef enum logic [1:0] {
		DPA_SRC_PC,
		DPA_SRC_TABLE,
		DPA_SRC_REMAP
	} dpa_psrc_e;

	// Extension operations on a working register.
	typedef enum logic [1:0] {
		DPA_EXT_NONE,
		DPA_EXT_SIGN,
		DPA_EXT_ZERO
	} dpa_ext_e;

	// One data-space access from the core.
	typedef struct packed {
		logic valid;
		logic write;
		logic is_byte;
		logic near_mode;
		logic post_inc;
		logic [15:0] effective_address;
		logic [15:0] wdata;
	} dpa_req_s;

	// Dual operand fetch for multiply-accumulate class operations.
	typedef struct packed {
		logic valid;
		logic [15:0] x_addr;
		logic [15:0] y_addr;
	} dpa_dual_s;

	// Program space access.
	typedef struct packed {
		logic valid;
		dpa_psrc_e src;
		logic [22:0] pc;
		logic [7:0] table_page;
		logic [15:0] offset;
	} dpa_preq_s;

endpackage

// ==== core/dpa_addr_unit.sv ====
/*
 * Data and program space address decode with a small flip-flop data store.
 * Holds byte lanes, page extension, zero-fill of unimplemented areas,
 * misalignment traps, X/Y dual fetch and program address forming.
 * Assumes the core issues at most one data request per cycle and reads
 * the answers one cycle after the request.
 */
// Summary of operation
// RL1 - Data effective addresses are 16-bit byte addresses, 64 Kbytes as 32K words.
// RL2 - Read page extends reads, write page extends writes, to a 16 Mbyte space.
// RL3 - Addresses beyond the implemented 52 Kbyte area return all zeros.
// RL4 - Low byte of a word sits at the even address, high byte at odd.
// RL5 - Post-increment adds one for byte operations and two for word operations.
// RL6 - Byte read fetches the word, address bit 0 picks byte onto low lane.
// RL7 - Byte write strobes only its own lane; the other half is unchanged.
// RL8 - Odd word access raises address error; a misaligned read still completes; the code leaves WREG_RESULT_O at WREG_I on a misaligned word read.
// RL9 - Misaligned word write executes but the memory write is suppressed.
// RL10 - Byte loads into a working register change only its low byte.
// RL11 - Sign-extend widens signed 8-bit to 16-bit; zero-extend clears upper byte.
// RL12 - Control register region 0x0000-0x0FFF reads zero where unused.
// RL13 - Near field reaches 0x0000-0x1FFF; 16-bit field or pointer reaches all.
// RL14 - Program addresses are 24-bit, from 23-bit counter, table or remap.
// RL15 - User program access stops at 0x7FFFFF except table reads with page bit 7.
// RL16 - Program location is even lower and odd upper word, stepped by two.
// RL17 - Vectors occupy 0x000000-0x000200; reset jump target sits at 0x000002.
// RL18 - Separate read and write generators; X read bus also prefetches X operand.
// RL19 - Multiply-accumulate class fetches X and Y operands concurrently.
// RL20 - Modulo in X and Y, bit-reverse only on X writes, none without DSP; the code has no modulo logic.
// RL21 - All writes use the unified X plus Y range with a fixed boundary.
// RL22 - A misaligned access outside memory traps rather than returning zero.
`timescale 1ns/1ns

module dpa_addr_unit
	import dpa_pkg::*;
(
	// Clock and reset.
	input wire logic CLK_SYS_I,
	input wire logic NRST_I,
	// Data access request and pages.
	input wire dpa_req_s REQ_I,
	input wire logic [7:0] DATA_READ_PAGE_I,
	input wire logic [7:0] DATA_WRITE_PAGE_I,
	input wire logic PAGE_LOAD_I,
	// Working register byte load and extension.
	input wire logic [15:0] WREG_I,
	input wire dpa_ext_e EXT_OP_I,
	input wire logic BIT_REVERSE_I,
	// Dual operand fetch.
	input wire dpa_dual_s DUAL_I,
	// Program space access.
	input wire dpa_preq_s PREQ_I,
	// Data answers.
	output logic [15:0] X_RDATA_O,
	output logic [15:0] Y_RDATA_O,
	output logic [15:0] WREG_RESULT_O,
	output logic [15:0] NEXT_POINTER_O,
	output logic [23:0] EXT_ADDRESS_O,
	output logic ADDR_ERROR_O,
	output logic WRITE_DONE_O,
	output logic Y_SPACE_O,
	// Program answers.
	output logic [23:0] PROG_ADDRESS_O,
	output logic PROG_UPPER_O,
	output logic PROG_VALID_O,
	output logic PROG_VECTOR_O,
	output logic PROG_REFUSED_O
);

	// Word index into the small store; only the RAM window is backed.
	function automatic logic [DPA_IDX_W-1:0] word_index(input logic [15:0] ea);
		logic [15:0] off;
		off = ea - DPA_RAM_BASE;
		return off[DPA_IDX_W:1];
	endfunction

	// An address is backed when it lies in the first 512 bytes of the RAM part, 0x1000-0x11FF.
	function automatic logic is_backed(input logic [15:0] ea);
		logic [15:0] off;
		off = ea - DPA_RAM_BASE;
		return (ea >= DPA_RAM_BASE) && (ea <= DPA_IMPL_LAST) && (off[15:DPA_IDX_W+1] == '0);
	endfunction

	// Every address past the implemented area reads as zero.
	function automatic logic is_impl(input logic [15:0] ea);
		return ea <= DPA_IMPL_LAST;
	endfunction

	// Lane pick: even address is the low byte.
	function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic odd);
		return odd ? w[15:8] : w[7:0];
	endfunction

	logic [7:0] mem_lo [DPA_DEPTH];
	logic [7:0] mem_hi [DPA_DEPTH];
	logic [7:0] rd_page_reg;
	logic [7:0] wr_page_reg;
	logic [15:0] ea;
	logic misaligned;
	logic wr_ok;
	logic [DPA_IDX_W-1:0] wr_idx;
	logic [15:0] x_word;
	logic [15:0] y_word;
	logic [15:0] x_rdata_next;
	logic [15:0] wreg_next;
	logic [15:0] ptr_next;
	logic [23:0] prog_next;
	logic prog_ok;

	// Near mode keeps only the 13-bit absolute field. (see RL13)
	assign ea = REQ_I.near_mode ? {3'h0, REQ_I.effective_address[DPA_NEAR_W-1:0]}
		: REQ_I.effective_address; // see RL1
	assign misaligned = REQ_I.valid && !REQ_I.is_byte && ea[0]; // see RL8

	// Writes go to the unified range; a misaligned word write never lands. (see RL9)
	assign wr_ok = REQ_I.valid && REQ_I.write && !misaligned && is_backed(ea); // see RL21
	assign wr_idx = word_index(ea);

	// Page registers; a write page applies only to writes, read page to reads.
	always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
		if (!NRST_I) begin
			rd_page_reg <= DPA_PAGE_RESET;
			wr_page_reg <= DPA_PAGE_RESET;
		end else if (PAGE_LOAD_I) begin
			rd_page_reg <= DATA_READ_PAGE_I;
			wr_page_reg <= DATA_WRITE_PAGE_I;
		end
	end

	// Byte lanes share a word decode but have separate strobes. (see RL7)
	// Storage carries no reset so it maps onto plain flip-flop arrays.
	always_ff @(posedge CLK_SYS_I) begin
		if (wr_ok && (!REQ_I.is_byte || !ea[0])) begin
			mem_lo[wr_idx] <= REQ_I.wdata[7:0]; // see RL4
		end
		if (wr_ok && (!REQ_I.is_byte || ea[0])) begin
			mem_hi[wr_idx] <= REQ_I.is_byte ? REQ_I.wdata[7:0] : REQ_I.wdata[15:8];
		end
	end

	// X read bus: unmapped and unused control addresses read zero. (see RL3)
	always_comb begin
		x_word = DPA_ZERO_WORD;
		if (is_backed(ea)) begin
			x_word = {mem_hi[wr_idx], mem_lo[wr_idx]};
		end else if (!is_impl(ea) || ea <= DPA_CTRL_LAST) begin
			x_word = DPA_ZERO_WORD; // see RL12
		end
		if (DUAL_I.valid && is_backed(DUAL_I.x_addr)) begin
			x_word = {mem_hi[word_index(DUAL_I.x_addr)], mem_lo[word_index(DUAL_I.x_addr)]};
		end
	end

	// Y path is independent so both operands come in one cycle. (see RL19)
	always_comb begin
		y_word = DPA_ZERO_WORD;
		if (DUAL_I.valid && is_backed(DUAL_I.y_addr)) begin
			y_word = {mem_hi[word_index(DUAL_I.y_addr)], mem_lo[word_index(DUAL_I.y_addr)]};
		end
	end

	// Byte reads land on the low lane. (see RL6)
	always_comb begin
		x_rdata_next = x_word;
		if (REQ_I.valid && !REQ_I.write && REQ_I.is_byte && !DUAL_I.valid) begin
			x_rdata_next = {DPA_ZERO_BYTE, pick_byte(x_word, ea[0])};
		end
	end

	// Working register result: byte load keeps the high byte, then extension.
	always_comb begin
		wreg_next = WREG_I;
		if (REQ_I.valid && !REQ_I.write && REQ_I.is_byte) begin
			wreg_next = {WREG_I[15:8], pick_byte(x_word, ea[0])}; // see RL10
		end else if (REQ_I.valid && !REQ_I.write && !misaligned) begin
			wreg_next = x_word;
		end
		unique case (EXT_OP_I)
			DPA_EXT_SIGN: wreg_next = {{DPA_BYTE_W{wreg_next[7]}}, wreg_next[7:0]}; // see RL11
			DPA_EXT_ZERO: wreg_next = {DPA_ZERO_BYTE, wreg_next[7:0]}; // see RL11
			default: wreg_next = wreg_next;
		endcase
	end

	// Post-increment step follows operand size. (see RL5)
	// Bit-reversed update applies only to X writes; reads step normally. (see RL20)
	always_comb begin
		ptr_next = REQ_I.effective_address;
		if (REQ_I.valid && REQ_I.post_inc) begin
			ptr_next = REQ_I.effective_address + (REQ_I.is_byte ? DPA_STEP_BYTE : DPA_STEP_WORD);
			if (BIT_REVERSE_I && REQ_I.write && ea < DPA_XY_BOUNDARY) begin
				ptr_next = {<<{REQ_I.effective_address}};
			end
		end
	end

	// Data answers, registered one cycle after the request.
	always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
		if (!NRST_I) begin
			X_RDATA_O <= DPA_ZERO_WORD;
			Y_RDATA_O <= DPA_ZERO_WORD;
			WREG_RESULT_O <= DPA_ZERO_WORD;
			NEXT_POINTER_O <= DPA_ZERO_WORD;
		end else begin
			X_RDATA_O <= x_rdata_next; // see RL18
			Y_RDATA_O <= y_word;
			WREG_RESULT_O <= wreg_next;
			NEXT_POINTER_O <= ptr_next;
		end
	end

	// Extended address pairs the page for the direction with the base address.
	always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
		if (!NRST_I) begin
			EXT_ADDRESS_O <= '0;
			Y_SPACE_O <= 1'b0;
		end else begin
			EXT_ADDRESS_O <= {REQ_I.write ? wr_page_reg : rd_page_reg, ea}; // see RL2
			Y_SPACE_O <= REQ_I.valid && (ea >= DPA_XY_BOUNDARY) && is_impl(ea); // see RL21
		end
	end

	// Trap wins over zero fill, so it is raised even off the map. (see RL22)
	always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
		if (!NRST_I) begin
			ADDR_ERROR_O <= 1'b0;
			WRITE_DONE_O <= 1'b0;
		end else begin
			ADDR_ERROR_O <= misaligned; // see RL8
			WRITE_DONE_O <= wr_ok; // see RL9
		end
	end

	// Program address forming from the counter, table page or remap window.
	always_comb begin
		prog_next = '0;
		unique case (PREQ_I.src)
			DPA_SRC_PC: prog_next = {1'b0, PREQ_I.pc}; // see RL14
			DPA_SRC_TABLE: prog_next = {PREQ_I.table_page, PREQ_I.offset};
			// The whole read page is used, so a page with its top bit set lands above
			// the user limit and the remap is refused rather than silently folded down.
			DPA_SRC_REMAP: prog_next = {rd_page_reg, PREQ_I.offset};
			default: prog_next = '0;
		endcase
		prog_ok = (prog_next <= DPA_USER_LAST)
			|| (PREQ_I.src == DPA_SRC_TABLE && PREQ_I.table_page[DPA_TBL_CFG_BIT]); // see RL15
	end

	// Program answers; the lower word is always at an even address. (see RL16)
	always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
		if (!NRST_I) begin
			PROG_ADDRESS_O <= DPA_RESET_TARGET - DPA_PROG_STEP; // see RL17
			PROG_UPPER_O <= 1'b0;
			PROG_VALID_O <= 1'b0;
			PROG_VECTOR_O <= 1'b0;
			PROG_REFUSED_O <= 1'b0;
		end else begin
			PROG_ADDRESS_O <= {prog_next[23:1], 1'b0}; // see RL16
			PROG_UPPER_O <= prog_next[0];
			PROG_VALID_O <= PREQ_I.valid && prog_ok;
			PROG_VECTOR_O <= PREQ_I.valid && (prog_next <= DPA_VECTOR_LAST); // see RL17
			PROG_REFUSED_O <= PREQ_I.valid && !prog_ok;
		end
	end

	// Odd word access raises the trap one cycle later.
	chk_odd_word_trap: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I) // see RL8
		REQ_I.valid && !REQ_I.is_byte && !REQ_I.near_mode && REQ_I.effective_address[0]
		|=> ADDR_ERROR_O) else $error("odd word access gave no trap");

	// A misaligned write never completes.
	chk_bad_write_blocked: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I) // see RL9
		ADDR_ERROR_O |-> !WRITE_DONE_O) else $error("misaligned write landed");

	// Post-increment step matches operand size.
	chk_step_size: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I) // see RL5
		REQ_I.valid && REQ_I.post_inc && !REQ_I.write
		|=> NEXT_POINTER_O == $past(REQ_I.effective_address)
		+ ($past(REQ_I.is_byte) ? DPA_STEP_BYTE : DPA_STEP_WORD)) else $error("wrong step");

	// Byte loads leave the high byte of the register alone.
	chk_byte_keep_high: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I) // see RL10
		REQ_I.valid && !REQ_I.write && REQ_I.is_byte && EXT_OP_I == DPA_EXT_NONE
		|=> WREG_RESULT_O[15:8] == $past(WREG_I[15:8])) else $error("high byte touched");

	// Out-of-area reads return zero.
	chk_zero_fill: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I) // see RL3
		REQ_I.valid && !REQ_I.write && !REQ_I.near_mode && !DUAL_I.valid
		&& REQ_I.effective_address > DPA_IMPL_LAST |=> X_RDATA_O == DPA_ZERO_WORD)
		else $error("unmapped read not zero");

	// Byte reads leave the upper lane empty.
	chk_byte_low_lane: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I) // see RL6
		REQ_I.valid && !REQ_I.write && REQ_I.is_byte && !DUAL_I.valid
		|=> X_RDATA_O[15:8] == DPA_ZERO_BYTE) else $error("byte read on high lane");

	// Write direction uses the write page.
	chk_write_page: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I) // see RL2
		REQ_I.write && !PAGE_LOAD_I ##1 REQ_I.write
		|=> EXT_ADDRESS_O[23:16] == $past(wr_page_reg)) else $error("wrong page");

	// Table reads with the configuration page bit pass the user limit.
	chk_user_limit: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I) // see RL15
		PREQ_I.valid && PREQ_I.src == DPA_SRC_TABLE && PREQ_I.table_page[DPA_TBL_CFG_BIT]
		|=> PROG_VALID_O && !PROG_REFUSED_O) else $error("config read refused");

	// Program addresses are always even.
	chk_prog_even: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I) // see RL16
		PROG_VALID_O |-> !PROG_ADDRESS_O[0]) else $error("odd program address");

	// A page load followed by one quiet cycle governs the request in that cycle.
	sequence pages_loaded;
		PAGE_LOAD_I ##1 !PAGE_LOAD_I;
	endsequence

	// The freshly loaded page of the request's own direction is applied.
	chk_loaded_page: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I) // see RL2
		pages_loaded |=> EXT_ADDRESS_O[23:16] == ($past(REQ_I.write)
		? $past(DATA_WRITE_PAGE_I, 2) : $past(DATA_READ_PAGE_I, 2)))
		else $error("loaded page not applied");

	// Odd byte writes leave the even lane alone. The store has no reset, so this
	// only holds its meaning once the even lane of that word has been written.
	chk_odd_lane_only: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I) // see RL7
		wr_ok && REQ_I.is_byte && ea[0]
		|=> mem_lo[$past(wr_idx)] == $past(mem_lo[wr_idx])) else $error("even lane disturbed");

	// The trap is raised even where the read would have been zero filled.
	chk_trap_off_map: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I) // see RL22
		REQ_I.valid && !REQ_I.is_byte && ea[0] && !is_impl(ea)
		|=> ADDR_ERROR_O) else $error("off-map misaligned access gave no trap");

	// The Y flag follows the fixed boundary up to the end of the implemented area.
	chk_y_boundary: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I) // see RL21
		REQ_I.valid && ea >= DPA_XY_BOUNDARY && ea <= DPA_IMPL_LAST
		|=> Y_SPACE_O) else $error("Y region access not flagged");

	// The Y path carries nothing unless a dual fetch is under way.
	chk_y_idle_zero: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I) // see RL19
		!DUAL_I.valid |=> Y_RDATA_O == DPA_ZERO_WORD) else $error("Y bus busy without dual fetch");

	// Counter fetches inside the vector area are flagged.
	chk_vector_flag: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I) // see RL17
		PREQ_I.valid && PREQ_I.src == DPA_SRC_PC && {1'b0, PREQ_I.pc} <= DPA_VECTOR_LAST
		|=> PROG_VECTOR_O) else $error("vector fetch not flagged");

	// A remap through a read page with its top bit set is refused.
	chk_remap_refused: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I) // see RL15
		PREQ_I.valid && PREQ_I.src == DPA_SRC_REMAP && rd_page_reg[DPA_TBL_CFG_BIT]
		|=> PROG_REFUSED_O && !PROG_VALID_O) else $error("remap above user limit accepted");

endmodule

// ==== dv/dpa_core_model.sv ====
/*
 * Core-side model that issues data, dual operand and program requests.
 * Assumes one bench process calls its tasks, one request at a time.
 */
`timescale 1ns/1ns

module dpa_core_model
	import dpa_pkg::*;
(
	// Clock.
	input wire logic clk_i,
	// Requests toward the addressing block.
	output dpa_req_s req_o,
	output dpa_dual_s dual_o,
	output dpa_preq_s preq_o
);
	// All request buses start idle.
	initial begin
		req_o = '0;
		dual_o = '0;
		preq_o = '0;
	end

	// One data access held for its taking edge; the released bus carries inverted stale fields.
	task automatic data_op(input logic wr, input logic byt, input logic near, input logic pinc,
		input logic [15:0] ea, input logic [15:0] wd);
		dpa_req_s r;
		r = '{1'b1, wr, byt, near, pinc, ea, wd};
		@(posedge clk_i) req_o <= r;
		r = ~r;
		r.valid = 1'b0;
		@(posedge clk_i) req_o <= r;
		#1;
	endtask

	// Concurrent X and Y operand fetch.
	task automatic dual_op(input logic [15:0] xa, input logic [15:0] ya);
		@(posedge clk_i) dual_o <= '{1'b1, xa, ya};
		@(posedge clk_i) dual_o <= '{1'b0, ~xa, ~ya};
		#1;
	endtask

	// Program space access.
	task automatic prog_op(input dpa_psrc_e src, input logic [22:0] pc, input logic [7:0] tp,
		input logic [15:0] off);
		@(posedge clk_i) preq_o <= '{1'b1, src, pc, tp, off};
		@(posedge clk_i) preq_o <= '{1'b0, src, ~pc, ~tp, ~off};
		#1;
	endtask
endmodule

// ==== dv/data_program_space_addressing_bench.sv ====
/*
 * Self-checking bench for the addressing block, driven through the core model.
 * Assumes every answer lands on the taking edge and is read 1 ns after it.
 */
`timescale 1ns/1ns

module data_program_space_addressing_bench;
	import dpa_pkg::*;

	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [15:0] wreg = 16'habcd;
	dpa_ext_e ext_op = DPA_EXT_NONE;
	logic [7:0] rd_page = 8'h01;
	logic [7:0] wr_page = 8'h01;
	logic page_load = 1'b0;
	logic bit_rev = 1'b0;
	dpa_req_s req;
	dpa_dual_s dual;
	dpa_preq_s preq;
	logic [15:0] x_rdata, y_rdata, wreg_res, next_ptr;
	logic [23:0] ext_addr, prog_addr;
	logic addr_err, wr_done, y_space, prog_upper, prog_valid, prog_vec, prog_ref;
	int bad_count = 0;
	int cmp_count = 0;
	int cycles = 0;

	// Core model and design.
	dpa_core_model core (.clk_i(clk), .req_o(req), .dual_o(dual), .preq_o(preq));
	dpa_addr_unit uut (.CLK_SYS_I(clk), .NRST_I(nrst), .REQ_I(req),
		.DATA_READ_PAGE_I(rd_page), .DATA_WRITE_PAGE_I(wr_page), .PAGE_LOAD_I(page_load),
		.WREG_I(wreg), .EXT_OP_I(ext_op), .BIT_REVERSE_I(bit_rev), .DUAL_I(dual), .PREQ_I(preq),
		.X_RDATA_O(x_rdata), .Y_RDATA_O(y_rdata), .WREG_RESULT_O(wreg_res),
		.NEXT_POINTER_O(next_ptr), .EXT_ADDRESS_O(ext_addr), .ADDR_ERROR_O(addr_err),
		.WRITE_DONE_O(wr_done), .Y_SPACE_O(y_space), .PROG_ADDRESS_O(prog_addr),
		.PROG_UPPER_O(prog_upper), .PROG_VALID_O(prog_valid), .PROG_VECTOR_O(prog_vec),
		.PROG_REFUSED_O(prog_ref));

	// Clock of 10 ns period.
	initial begin
		forever #5 clk = ~clk;
	end

	// Hang guard, far above the roughly 70 cycles the tests need.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			final_report();
		end
	end

	// Compares one value and reports a mismatch at once.
	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		cmp_count++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", what, exp, got);
			bad_count++;
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Outputs after reset are quiet and the program address sits at zero.
	task automatic t_reset();
		chk("prog_addr", 24'h000000, prog_addr);
		chk("addr_err", 24'h0, {23'h0, addr_err});
		chk("wr_done", 24'h0, {23'h0, wr_done});
		$display("test reset done");
	endtask

	// Byte lanes, pointer steps and the default read page.
	task automatic t_lanes();
		core.data_op(1'b1, 1'b0, 1'b0, 1'b1, 16'h1000, 16'ha59a);
		chk("wr_done", 24'h1, {23'h0, wr_done});
		chk("next_ptr word", 24'h1002, {8'h0, next_ptr});
		core.data_op(1'b1, 1'b1, 1'b0, 1'b1, 16'h1001, 16'h003c);
		chk("next_ptr byte", 24'h1002, {8'h0, next_ptr});
		core.data_op(1'b0, 1'b0, 1'b0, 1'b0, 16'h1000, 16'h0);
		chk("word read", 24'h3c9a, {8'h0, x_rdata});
		chk("ext read", 24'h011000, ext_addr);
		core.data_op(1'b0, 1'b1, 1'b0, 1'b0, 16'h1001, 16'h0);
		chk("odd byte", 24'h003c, {8'h0, x_rdata});
		$display("test lanes done");
	endtask

	// Misaligned word accesses trap and the write leaves the store alone.
	task automatic t_misalign();
		core.data_op(1'b1, 1'b0, 1'b0, 1'b0, 16'h1002, 16'h1234);
		core.data_op(1'b1, 1'b0, 1'b0, 1'b0, 16'h1003, 16'hffff);
		chk("trap on write", 24'h1, {23'h0, addr_err});
		chk("no write", 24'h0, {23'h0, wr_done});
		core.data_op(1'b0, 1'b0, 1'b0, 1'b0, 16'h1002, 16'h0);
		chk("kept word", 24'h1234, {8'h0, x_rdata});
		chk("trap one pulse", 24'h0, {23'h0, addr_err});
		core.data_op(1'b0, 1'b0, 1'b0, 1'b0, 16'h1001, 16'h0);
		chk("trap on read", 24'h1, {23'h0, addr_err});
		$display("test misalign done");
	endtask

	// Unimplemented and unused areas read zero; near mode wraps into 13 bits.
	task automatic t_regions();
		core.data_op(1'b0, 1'b0, 1'b0, 1'b0, 16'hd000, 16'h0);
		chk("beyond ram", 24'h0, {8'h0, x_rdata});
		core.data_op(1'b0, 1'b0, 1'b0, 1'b0, 16'hd001, 16'h0);
		chk("trap first", 24'h1, {23'h0, addr_err});
		core.data_op(1'b0, 1'b0, 1'b0, 1'b0, 16'h0800, 16'h0);
		chk("ctrl unused", 24'h0, {8'h0, x_rdata});
		core.data_op(1'b1, 1'b0, 1'b0, 1'b0, 16'h9000, 16'h5555);
		chk("y region", 24'h1, {23'h0, y_space});
		core.data_op(1'b0, 1'b0, 1'b1, 1'b0, 16'h3000, 16'h0);
		chk("near field", 24'h3c9a, {8'h0, x_rdata});
		$display("test regions done");
	endtask

	// Read and write pages extend their own direction only.
	task automatic t_pages();
		@(posedge clk) begin
			rd_page <= 8'h12;
			wr_page <= 8'h34;
			page_load <= 1'b1;
		end
		@(posedge clk) page_load <= 1'b0;
		core.data_op(1'b0, 1'b0, 1'b0, 1'b0, 16'h1000, 16'h0);
		chk("ext read page", 24'h121000, ext_addr);
		core.data_op(1'b1, 1'b0, 1'b0, 1'b0, 16'h1002, 16'h1234);
		chk("ext write page", 24'h341002, ext_addr);
		$display("test pages done");
	endtask

	// Byte load into a working register under one extension mode.
	task automatic wreg_case(input dpa_ext_e op, input logic [15:0] exp);
		@(posedge clk) ext_op <= op;
		core.data_op(1'b0, 1'b1, 1'b0, 1'b0, 16'h1000, 16'h0);
		chk("wreg result", {8'h0, exp}, {8'h0, wreg_res});
		$display("test wreg case done");
	endtask

	// Dual fetch and program space forming.
	task automatic t_fetch();
		core.dual_op(16'h1000, 16'h1002);
		chk("x operand", 24'h3c9a, {8'h0, x_rdata});
		chk("y operand", 24'h1234, {8'h0, y_rdata});
		core.prog_op(DPA_SRC_TABLE, 23'h0, 8'h00, 16'h0100);
		chk("vector addr", 24'h000100, prog_addr);
		chk("vector flag", 24'h1, {23'h0, prog_vec});
		core.prog_op(DPA_SRC_TABLE, 23'h0, 8'h00, 16'h0403);
		chk("upper addr", 24'h000402, prog_addr);
		chk("upper flag", 24'h1, {23'h0, prog_upper});
		chk("past vectors", 24'h0, {23'h0, prog_vec});
		core.prog_op(DPA_SRC_TABLE, 23'h0, 8'h80, 16'h0000);
		chk("cfg read ok", 24'h1, {22'h0, prog_ref, prog_valid});
		core.prog_op(DPA_SRC_PC, 23'h0, 8'h00, 16'h0);
		chk("pc zero", 24'h000000, prog_addr);
		$display("test fetch done");
	endtask

	// Bit-reversed pointer on X writes only, and remap through the read page.
	task automatic t_modes();
		@(posedge clk) begin
			bit_rev <= 1'b1;
			rd_page <= 8'h92;
			page_load <= 1'b1;
		end
		@(posedge clk) page_load <= 1'b0;
		core.data_op(1'b1, 1'b0, 1'b0, 1'b1, 16'h1000, 16'h3c9a);
		chk("reversed ptr", 24'h0008, {8'h0, next_ptr});
		core.data_op(1'b0, 1'b0, 1'b0, 1'b1, 16'h1000, 16'h0);
		chk("read step", 24'h1002, {8'h0, next_ptr});
		core.data_op(1'b1, 1'b0, 1'b0, 1'b1, 16'h9000, 16'h0);
		chk("y write step", 24'h9002, {8'h0, next_ptr});
		core.prog_op(DPA_SRC_REMAP, 23'h0, 8'h00, 16'h0400);
		chk("remap refused", 24'h2, {22'h0, prog_ref, prog_valid});
		chk("remap addr", 24'h920400, prog_addr);
		@(posedge clk) begin
			bit_rev <= 1'b0;
			rd_page <= 8'h12;
			page_load <= 1'b1;
		end
		@(posedge clk) page_load <= 1'b0;
		core.prog_op(DPA_SRC_REMAP, 23'h0, 8'h00, 16'h0400);
		chk("remap ok", 24'h1, {22'h0, prog_ref, prog_valid});
		chk("remap low", 24'h120400, prog_addr);
		$display("test modes done");
	endtask

	// Main sequence: reset for two cycles, then each test in turn.
	initial begin
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		#1;
		t_reset();
		t_lanes();
		t_misalign();
		t_regions();
		t_pages();
		wreg_case(DPA_EXT_NONE, 16'hab9a);
		wreg_case(DPA_EXT_SIGN, 16'hff9a);
		wreg_case(DPA_EXT_ZERO, 16'h009a);
		t_fetch();
		t_modes();
		final_report();
	end
endmodule
